// File: bench/pmtc_act_model.sv
/*
  Switch actuator model: follows lighting telegrams, runs a staircase timer
  and reports its switching state on change.
  Assumes one-cycle telegram strobes synchronous to ref_clk_in.
*/
`timescale 1ns/10ps

module pmtc_act_model #(
  parameter int RUN = 40
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic cmd_tx_in,
  input  wire logic cmd_val_in,
  input  wire logic stair_in,
  output logic      stat_tx_out,
  output logic      stat_val_out,
  output logic      light_out
);
  int   tmr_ff;
  logic nxt_light;

  always_comb begin
    nxt_light = light_out;
    if (cmd_tx_in)
      nxt_light = cmd_val_in | stair_in;
    else if (stair_in && tmr_ff == 1)
      nxt_light = 1'h0;
  end

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tmr_ff       <= 0;
      light_out    <= 1'h0;
      stat_tx_out  <= 1'h0;
      stat_val_out <= 1'h0;
    end else begin
      if (cmd_tx_in && cmd_val_in)
        tmr_ff <= RUN;
      else if (tmr_ff > 0)
        tmr_ff <= tmr_ff - 1;
      light_out    <= nxt_light;
      stat_tx_out  <= nxt_light != light_out;
      stat_val_out <= nxt_light;
    end
  end
endmodule

// File: bench/pmtc_chk_sva.sv
/*
  Port-level assertions of the presence coordination block.
  Assumes the bench keeps the lockout time at two seconds or more.
*/
`timescale 1ns/10ps

module pmtc_chk (
  input wire ref_clk_in, rst_in, role_main_in, universal_mode_in,
  input wire staircase_mode_in, dusk_indep_cfg_in, motion_in, bright_below_in,
  input wire ext_motion_valid_in, ext_motion_val_in,
  input wire dusk_check_disable_input_valid_in, dusk_check_disable_input_val_in,
  input wire sensor_lockout_input_valid_in, switch_tx_out, switch_val_out,
  input wire dusk_tx_out, dusk_val_out, motion_tx_out, lockout_active_out,
  input wire dusk_disabled_out, detect_active_out, run_on_active_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire main_u = role_main_in & universal_mode_in & ~staircase_mode_in;
  wire part   = ~role_main_in & staircase_mode_in;
  wire idle   = ~detect_active_out & ~run_on_active_out & ~lockout_active_out;
  sequence s_on;
    switch_tx_out && switch_val_out;
  endsequence
  sequence s_off;
    switch_tx_out && !switch_val_out;
  endsequence

  a_lock_start: assert property (sensor_lockout_input_valid_in |-> ##2 lockout_active_out)
    else $error("lockout not started");
  // The lockout output lags the internal lockout by one cycle after a strobe
  a_main_on: assert property (role_main_in && idle && motion_in
    && !$past(sensor_lockout_input_valid_in)
    && (bright_below_in || dusk_indep_cfg_in) |=> s_on)
    else $error("no switch on");
  a_univ_on: assert property ((main_u and s_on) |-> dusk_tx_out && dusk_val_out)
    else $error("no dusk on");
  a_univ_off: assert property ((main_u and s_off) |-> dusk_tx_out && !dusk_val_out)
    else $error("no dusk off");
  a_runon_end: assert property (role_main_in && !staircase_mode_in
    && $fell(run_on_active_out) && !detect_active_out |-> s_off)
    else $error("no off at run-on end");
  a_stair_on_only: assert property (role_main_in && staircase_mode_in && switch_tx_out
    |-> switch_val_out)
    else $error("staircase off sent");
  a_report_cause: assert property (motion_tx_out |-> !role_main_in && $past(motion_in))
    else $error("report without motion");
  a_partner_on: assert property (part && ext_motion_valid_in && ext_motion_val_in
    |=> dusk_disabled_out)
    else $error("partner on ignored");
  a_partner_off: assert property (part && ext_motion_valid_in && !ext_motion_val_in
    |=> !dusk_disabled_out)
    else $error("partner off ignored");
  a_ext_follow: assert property (!role_main_in && !staircase_mode_in
    && dusk_check_disable_input_valid_in
    |=> dusk_disabled_out == $past(dusk_check_disable_input_val_in))
    else $error("dusk flag wrong");
endmodule

bind pmtc_top pmtc_chk u_chk (.*);

// File: bench/test_pmtc_top.sv
/*
  Self-checking bench of the presence coordination block with an actuator.
  Assumes the one-second tick is shortened to SEC clock cycles.
*/
`timescale 1ns/10ps
`include "pmtc_defines.vh"

module test_pmtc_top;
  localparam int SEC = 20;
  logic ref_clk_in = 1'h0, rst_in = 1'h1, role_main_in = 1'h1, universal_mode_in = 1'h1;
  logic staircase_mode_in = 1'h0, dusk_indep_cfg_in = 1'h0, motion_in = 1'h0;
  logic bright_below_in = 1'h1, ext_motion_valid_in = 1'h0, ext_motion_val_in = 1'h0;
  logic dusk_check_disable_input_valid_in = 1'h0, dusk_check_disable_input_val_in = 1'h0;
  logic [`PMTC_TMR_W-1:0] run_on_sec_in = 16'h0002, cycle_sec_in = 16'h0001;
  logic [`PMTC_TMR_W-1:0] lockout_sec_in = 16'h0002;
  wire sensor_lockout_input_valid_in, sensor_lockout_input_val_in, light;
  wire switch_tx_out, switch_val_out, dusk_tx_out, dusk_val_out, motion_tx_out;
  wire lockout_active_out, dusk_disabled_out, detect_active_out, run_on_active_out;
  int err_count = 0, checked = 0, on_cnt = 0, off_cnt = 0, rep_cnt = 0, n;

  always #5 ref_clk_in = ~ref_clk_in;

  pmtc_top #(.SEC_CYCLES(SEC)) dut (.*);
  pmtc_act_model #(.RUN(2 * SEC)) u_act (.ref_clk_in, .rst_in, .cmd_tx_in(switch_tx_out),
    .cmd_val_in(switch_val_out), .stair_in(staircase_mode_in),
    .stat_tx_out(sensor_lockout_input_valid_in),
    .stat_val_out(sensor_lockout_input_val_in), .light_out(light));

  always @(posedge ref_clk_in) begin
    on_cnt  += (switch_tx_out & switch_val_out) === 1'h1;
    off_cnt += (switch_tx_out & ~switch_val_out) === 1'h1;
    rep_cnt += motion_tx_out === 1'h1;
  end

  task step(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  task chk(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task chkr(input string what, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task pulse_mot();
    motion_in = 1'h1;
    step(1);
    motion_in = 1'h0;
  endtask
  task ext_tel(input logic v);
    ext_motion_valid_in = 1'h1;
    ext_motion_val_in = v;
    step(1);
    ext_motion_valid_in = 1'h0;
  endtask
  task dusk_tel(input logic v);
    dusk_check_disable_input_valid_in = 1'h1;
    dusk_check_disable_input_val_in = v;
    step(1);
    dusk_check_disable_input_valid_in = 1'h0;
  endtask
  task wait_off();
    n = 0;
    while (!(switch_tx_out === 1'h1 && switch_val_out === 1'h0) && n < 400) begin
      step(1);
      n++;
    end
  endtask
  task conclude();
    $display("counts: %0d checked, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Far above the roughly 1300 cycles the tests need
  initial begin
    step(6000);
    err_count++;
    conclude();
  end

  initial begin
    step(8);
    rst_in = 1'h0;
    step(2);
    pulse_mot();
    chk("switch on", 1'h1, switch_tx_out & switch_val_out);
    chk("dusk on", 1'h1, dusk_tx_out & dusk_val_out);
    step(3);
    chk("lockout", 1'h1, lockout_active_out);
    wait_off();
    chkr("hold time", 195, 245, n);
    chk("dusk off", 1'h1, dusk_tx_out & ~dusk_val_out);
    step(4);
    pulse_mot();
    chk("locked motion", 1'h0, switch_tx_out);
    $display("test universal main done");
    step(50);
    bright_below_in = 1'h0;
    pulse_mot();
    chk("bright refused", 1'h0, switch_tx_out);
    dusk_indep_cfg_in = 1'h1;
    on_cnt = 0;
    ext_tel(1'h1);
    chk("dusk on indep", 1'h1, dusk_tx_out & dusk_val_out);
    step(SEC - 1);
    repeat (2) begin
      ext_tel(1'h1);
      step(SEC - 1);
    end
    chkr("report start", 1, 1, on_cnt);
    chk("report detect", 1'h1, detect_active_out);
    wait_off();
    chkr("report hold", 176, 226, n);
    $display("test external reports done");
    dusk_indep_cfg_in = 1'h0;
    step(50);
    staircase_mode_in = 1'h1;
    universal_mode_in = 1'h0;
    bright_below_in = 1'h1;
    on_cnt = 0;
    off_cnt = 0;
    motion_in = 1'h1;
    step(80);
    chkr("cyclic on", 4, 5, on_cnt);
    motion_in = 1'h0;
    step(300);
    chkr("no off", 0, 0, off_cnt);
    chk("light off", 1'h0, light);
    $display("test staircase main done");
    staircase_mode_in = 1'h0;
    step(50);
    role_main_in = 1'h0;
    rep_cnt = 0;
    motion_in = 1'h1;
    step(70);
    chkr("reports", 3, 5, rep_cnt);
    motion_in = 1'h0;
    step(2);
    rep_cnt = 0;
    step(60);
    chkr("reports stop", 0, 0, rep_cnt);
    bright_below_in = 1'h0;
    pulse_mot();
    chk("bright report", 1'h0, motion_tx_out);
    dusk_tel(1'h1);
    chk("dusk flag", 1'h1, dusk_disabled_out);
    pulse_mot();
    chk("forced report", 1'h1, motion_tx_out);
    dusk_tel(1'h0);
    chk("dusk flag clear", 1'h0, dusk_disabled_out);
    $display("test extension done");
    staircase_mode_in = 1'h1;
    rep_cnt = 0;
    ext_tel(1'h1);
    chk("partner on", 1'h1, dusk_disabled_out);
    // Spacing chosen so the first ON alone would have expired by the hold check
    step(15);
    ext_tel(1'h1);
    step(15);
    ext_tel(1'h1);
    step(14);
    chk("partner hold", 1'h1, dusk_disabled_out);
    step(30);
    chk("partner expire", 1'h0, dusk_disabled_out);
    ext_tel(1'h1);
    step(1);
    ext_tel(1'h0);
    chk("partner off", 1'h0, dusk_disabled_out);
    chk("partner no motion", 1'h0, (rep_cnt != 0) | detect_active_out);
    $display("test staircase partner done");
    conclude();
  end
endmodule

// File: inc/pmtc_defines.vh
/*
  Shared constants of the presence coordination block: timing figures,
  counter widths and fixed delays.
  Assumes a single 100 MHz clock; every slower rate is derived by division.
*/
`ifndef PMTC_DEFINES_VH
`define PMTC_DEFINES_VH

// Clock period and one second, both in ns
`define PMTC_CLK_PERIOD_NS 10
`define PMTC_SEC_NS        1000000000
// Clock cycles per one-second tick
`define PMTC_SEC_CYCLES    (`PMTC_SEC_NS / `PMTC_CLK_PERIOD_NS)
// Width of the one-second divider counter
`define PMTC_DIV_W         27

// Width of every seconds timer
`define PMTC_TMR_W         16
// Standard delay after the last motion: 10 s
`define PMTC_STD_DELAY_S   16'h000A

// Reset values of the telegram and status flops and of the timer counts
`define PMTC_RST_BIT       1'b0
`define PMTC_RST_TMR       16'h0000

`endif

// File: src/pmtc_tick.v
/*
  One-second enable generator: a free running divider that issues a
  single-cycle pulse every DIV clock cycles.
  Assumes DIV is at least 2 and fits the divider width.
*/
`timescale 1ns/10ps
`include "pmtc_defines.vh"

module pmtc_tick #(
  parameter DIV = `PMTC_SEC_CYCLES
) (
  input  wire ref_clk_in,
  input  wire rst_in,
  output reg  tick_out
);

  // Cut on purpose: DIV is a 32-bit parameter but always fits the divider
  localparam [31:0]            LAST_FULL = DIV - 1;
  localparam [`PMTC_DIV_W-1:0] LAST      = LAST_FULL[`PMTC_DIV_W-1:0];

  reg [`PMTC_DIV_W-1:0] div_ff;

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_ff   <= {`PMTC_DIV_W{1'b0}};
      tick_out <= `PMTC_RST_BIT;
    end else if (div_ff == LAST) begin
      div_ff   <= {`PMTC_DIV_W{1'b0}};
      tick_out <= 1'b1;
    end else begin
      div_ff   <= div_ff + {{(`PMTC_DIV_W-1){1'b0}}, 1'b1};
      tick_out <= 1'b0;
    end
  end

endmodule

// File: src/pmtc_timer.v
/*
  Seconds countdown timer. A load restarts it, a clear stops it silently,
  and it pulses expire_out for one cycle when the count reaches zero.
  Loading zero expires at once. Assumes tick_in is a one-cycle pulse.
*/
`timescale 1ns/10ps
`include "pmtc_defines.vh"

module pmtc_timer (
  input  wire                   ref_clk_in,
  input  wire                   rst_in,
  input  wire                   tick_in,
  input  wire                   load_in,
  input  wire [`PMTC_TMR_W-1:0] load_val_in,
  input  wire                   clr_in,
  output reg                    busy_out,
  output reg                    expire_out
);

  reg [`PMTC_TMR_W-1:0] cnt_ff;
  reg [`PMTC_TMR_W-1:0] nxt_cnt;
  reg                   nxt_exp;

  always @* begin
    nxt_cnt = cnt_ff;
    nxt_exp = 1'b0;
    if (clr_in) begin
      nxt_cnt = `PMTC_RST_TMR;
    end else if (load_in) begin
      nxt_cnt = load_val_in;
      nxt_exp = (load_val_in == `PMTC_RST_TMR);
    end else if (tick_in && cnt_ff != `PMTC_RST_TMR) begin
      nxt_cnt = cnt_ff - {{(`PMTC_TMR_W-1){1'b0}}, 1'b1};
      nxt_exp = (nxt_cnt == `PMTC_RST_TMR);
    end
  end

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff     <= `PMTC_RST_TMR;
      busy_out   <= `PMTC_RST_BIT;
      expire_out <= `PMTC_RST_BIT;
    end else begin
      cnt_ff     <= nxt_cnt;
      busy_out   <= (nxt_cnt != `PMTC_RST_TMR);
      expire_out <= nxt_exp;
    end
  end

endmodule

// File: src/pmtc_top.v
/*
  Coordination logic of a presence detector acting as main unit or as
  extension: light switching telegrams, cyclic motion reports, remote
  disabling of the dusk check and the sensor lockout from status feedback.
  Assumes every bus telegram arrives as a one-cycle valid strobe with its
  1-bit value, synchronous to ref_clk_in, and that telegram outputs are
  one-cycle strobes picked up by the bus interface outside.
*/
// What this block does
// - Any lockout-input telegram restarts the lockout time
// - Main sends ON when motion under dusk
// - Universal scheme: dusk-disable ON at detection start
// - Run-on expiry: OFF to actuator unless staircase, and to extensions in universal scheme only
// - Extension obeys dusk-disable ON and OFF unless staircase (partner)
// - Extension reports motion cyclically while sensing it
// - Reports count as motion; silence starts run-on
// - Dusk-disable telegrams sent even if brightness-independent
// - Staircase: cyclic ON until the ten-second hold ends, then silence
// - Partner extension: external ON disables dusk check
// - Partner: ON restarts run-on; expiry re-enables check
// - Partner: external OFF re-enables dusk check at once
// - Partner mode uses run-on delay as actuator time
// - Hold is ten seconds, then the run-on delay
`timescale 1ns/10ps
`include "pmtc_defines.vh"

module pmtc_top #(
  parameter SEC_CYCLES = `PMTC_SEC_CYCLES
) (
  input  wire                   ref_clk_in,
  input  wire                   rst_in,
  // Configuration
  input  wire                   role_main_in,
  input  wire                   universal_mode_in,
  input  wire                   staircase_mode_in,
  input  wire                   dusk_indep_cfg_in,
  input  wire [`PMTC_TMR_W-1:0] run_on_sec_in,
  input  wire [`PMTC_TMR_W-1:0] cycle_sec_in,
  input  wire [`PMTC_TMR_W-1:0] lockout_sec_in,
  // Sensor side
  input  wire                   motion_in,
  input  wire                   bright_below_in,
  // Received telegrams
  input  wire                   ext_motion_valid_in,
  input  wire                   ext_motion_val_in,
  input  wire                   dusk_check_disable_input_valid_in,
  input  wire                   dusk_check_disable_input_val_in,
  input  wire                   sensor_lockout_input_valid_in,
  input  wire                   sensor_lockout_input_val_in,
  // Transmitted telegrams
  output reg                    switch_tx_out,
  output reg                    switch_val_out,
  output reg                    dusk_tx_out,
  output reg                    dusk_val_out,
  output reg                    motion_tx_out,
  // Status
  output reg                    lockout_active_out,
  output reg                    dusk_disabled_out,
  output reg                    detect_active_out,
  output reg                    run_on_active_out
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_HOLD  = 2'h1;
  localparam [1:0] ST_RUNON = 2'h2;

  wire sec_tick;
  wire lock_busy;
  wire std_expire;
  wire run_expire;
  wire cyc_expire;
  wire part_expire;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg       dusk_dis_ff;
  reg       nxt_dusk_dis;
  reg       rep_on_ff;
  reg       nxt_rep_on;

  reg       nxt_sw_tx;
  reg       nxt_sw_val;
  reg       nxt_dk_tx;
  reg       nxt_dk_val;
  reg       nxt_mot_tx;
  reg       std_load;
  reg       run_load;
  reg       run_clr;
  reg       cyc_load;
  reg       part_load;

  pmtc_tick #(
    .DIV (SEC_CYCLES)
  ) u_tick (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .tick_out   (sec_tick)
  );

  // status change restarts lockout
  // The value is ignored on purpose: switching on and off both lock.
  pmtc_timer u_lock (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .tick_in     (sec_tick),
    .load_in     (sensor_lockout_input_valid_in),
    .load_val_in (lockout_sec_in),
    .clr_in      (1'b0),
    .busy_out    (lock_busy),
    .expire_out  ()
  );

  pmtc_timer u_std (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .tick_in     (sec_tick),
    .load_in     (std_load),
    .load_val_in (`PMTC_STD_DELAY_S),
    .clr_in      (1'b0),
    .busy_out    (),
    .expire_out  (std_expire)
  );

  pmtc_timer u_run (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .tick_in     (sec_tick),
    .load_in     (run_load),
    .load_val_in (run_on_sec_in),
    .clr_in      (run_clr),
    .busy_out    (),
    .expire_out  (run_expire)
  );

  // Shared by staircase ON repeats (main) and motion reports (extension)
  pmtc_timer u_cyc (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .tick_in     (sec_tick),
    .load_in     (cyc_load),
    .load_val_in (cycle_sec_in),
    .clr_in      (1'b0),
    .busy_out    (),
    .expire_out  (cyc_expire)
  );

  pmtc_timer u_part (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .tick_in     (sec_tick),
    .load_in     (part_load),
    .load_val_in (run_on_sec_in),
    .clr_in      (1'b0),
    .busy_out    (),
    .expire_out  (part_expire)
  );

  wire partner  = ~role_main_in & staircase_mode_in;
  wire ext_on   = ext_motion_valid_in & ext_motion_val_in;
  wire ext_off  = ext_motion_valid_in & ~ext_motion_val_in;
  wire own_mot  = motion_in & ~lock_busy;
  // partner does not take ON as motion
  wire ext_mot  = ext_on & ~partner;
  wire any_mot  = own_mot | ext_mot;
  wire dusk_ok  = bright_below_in | dusk_indep_cfg_in | dusk_dis_ff;
  wire stair_mn = role_main_in & staircase_mode_in;
  wire univ_mn  = role_main_in & universal_mode_in & ~staircase_mode_in;

  // Dusk-check disable state of an extension
  always @* begin
    nxt_dusk_dis = dusk_dis_ff;
    part_load    = 1'b0;
    if (role_main_in) begin
      nxt_dusk_dis = 1'b0;
    end else if (partner) begin
      if (ext_on) begin
        nxt_dusk_dis = 1'b1;
        part_load    = 1'b1;
      end else if (ext_off) begin
        nxt_dusk_dis = 1'b0;
      end else if (part_expire) begin
        nxt_dusk_dis = 1'b0;
      end
    end else if (dusk_check_disable_input_valid_in) begin
      nxt_dusk_dis = dusk_check_disable_input_val_in;
    end
  end

  // Detection sequence of the main unit and motion reports of extensions
  always @* begin
    nxt_state  = state_ff;
    nxt_rep_on = rep_on_ff;
    nxt_sw_tx  = 1'b0;
    nxt_sw_val = switch_val_out;
    nxt_dk_tx  = 1'b0;
    nxt_dk_val = dusk_val_out;
    nxt_mot_tx = 1'b0;
    std_load   = 1'b0;
    run_load   = 1'b0;
    run_clr    = 1'b0;
    cyc_load   = 1'b0;
    if (!role_main_in) begin
      nxt_state = ST_IDLE;
      run_clr   = 1'b1;
      if (!own_mot) begin
        nxt_rep_on = 1'b0;
      end else if (!rep_on_ff && dusk_ok) begin
        nxt_rep_on = 1'b1;
        nxt_mot_tx = 1'b1;
        cyc_load   = 1'b1;
      end else if (rep_on_ff && cyc_expire) begin
        nxt_mot_tx = 1'b1;
        cyc_load   = 1'b1;
      end
    end else begin
      nxt_rep_on = 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (any_mot && dusk_ok) begin
            nxt_state  = ST_HOLD;
            std_load   = 1'b1;
            nxt_sw_tx  = 1'b1;
            nxt_sw_val = 1'b1;
            cyc_load   = stair_mn;
            // dusk-disable ON regardless of own check
            nxt_dk_tx  = univ_mn;
            nxt_dk_val = univ_mn ? 1'b1 : dusk_val_out;
          end
        end
        ST_HOLD: begin
          if (any_mot) begin
            std_load = 1'b1;
          end else if (std_expire) begin
            nxt_state = ST_RUNON;
            run_load  = 1'b1;
          end
          if (stair_mn && cyc_expire) begin
            nxt_sw_tx  = 1'b1;
            nxt_sw_val = 1'b1;
            cyc_load   = 1'b1;
          end
        end
        ST_RUNON: begin
          if (any_mot) begin
            // Retrigger: staircase resumes its ON repeats at once
            nxt_state  = ST_HOLD;
            std_load   = 1'b1;
            run_clr    = 1'b1;
            nxt_sw_tx  = stair_mn;
            cyc_load   = stair_mn;
          end else if (run_expire) begin
            nxt_state = ST_IDLE;
            nxt_sw_tx  = ~staircase_mode_in;
            nxt_sw_val = staircase_mode_in ? switch_val_out : 1'b0;
            nxt_dk_tx  = univ_mn;
            nxt_dk_val = univ_mn ? 1'b0 : dusk_val_out;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff           <= ST_IDLE;
      dusk_dis_ff        <= `PMTC_RST_BIT;
      rep_on_ff          <= `PMTC_RST_BIT;
      switch_tx_out      <= `PMTC_RST_BIT;
      switch_val_out     <= `PMTC_RST_BIT;
      dusk_tx_out        <= `PMTC_RST_BIT;
      dusk_val_out       <= `PMTC_RST_BIT;
      motion_tx_out      <= `PMTC_RST_BIT;
      lockout_active_out <= `PMTC_RST_BIT;
      dusk_disabled_out  <= `PMTC_RST_BIT;
      detect_active_out  <= `PMTC_RST_BIT;
      run_on_active_out  <= `PMTC_RST_BIT;
    end else begin
      state_ff           <= nxt_state;
      dusk_dis_ff        <= nxt_dusk_dis;
      rep_on_ff          <= nxt_rep_on;
      switch_tx_out      <= nxt_sw_tx;
      switch_val_out     <= nxt_sw_val;
      dusk_tx_out        <= nxt_dk_tx;
      dusk_val_out       <= nxt_dk_val;
      motion_tx_out      <= nxt_mot_tx;
      lockout_active_out <= lock_busy;
      dusk_disabled_out  <= nxt_dusk_dis;
      detect_active_out  <= (nxt_state == ST_HOLD) | nxt_rep_on;
      run_on_active_out  <= (nxt_state == ST_RUNON);
    end
  end

endmodule
